// file: enc8_counter_top.sv
// Eight-channel 32-bit up/down encoder counter with filters and interval timer.
// Assumes an APB master on clk and asynchronous pins that are synchronised here.
// Operation
// RL1 - Eight independent channels, each a 32-bit up/down count.
// RL2 - Modes: two-phase quadrature, up/down pulses, gated single-phase.
// RL3 - Count is plain binary, 32 bits wide.
// RL4 - Inputs per channel: A or up, B or down, index_or_clear_pulse.
// RL5 - Software picks differential or single-ended input per channel.
// RL6 - Broken differential line is detected and reported.
// RL7 - Noise filter on A, B, Z, control; bypass or 0.1us to 1.6384ms.
// RL8 - Filtered inputs arrive late by the set filter duration.
// RL9 - Control input: start/stop, preset, zero clear or plain input.
// RL10 - Independent interval timer raises an interrupt each interval.
// RL11 - Timer interval 1 to 6553 ms in 1 ms steps.
// RL12 - Inputs count correctly up to 10 MHz.
// RL13 - Filter duration set separately per channel.
// RL14 - Counting starts by software, external start or sampling trigger.
// RL15 - Quadrature counts up when A leads, down when B leads.
// RL16 - Count wraps around at both ends.
`timescale 1ns/1ps
module enc8_counter_top
  import enc8_pkg::*;
#(
  parameter int unsigned MS_CYC = TMR_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] diffA,
  input wire logic [NCH-1:0] diffB,
  input wire logic [NCH-1:0] diffZ,
  input wire logic [NCH-1:0] ttlA,
  input wire logic [NCH-1:0] ttlB,
  input wire logic [NCH-1:0] ttlZ,
  input wire logic [NCH-1:0] ctlIn,
  input wire logic [NCH-1:0] lineFault,
  input wire logic extStart,
  input wire logic sampStart,
  output logic irq
);

  localparam int unsigned PW = 8 * NCH + 2;
  localparam int unsigned NF = 4 * NCH;
  localparam int unsigned MW = $clog2(MS_CYC);

  if (MS_CYC < 2) begin : g_chk
    $error("MS_CYC must be at least 2");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PW-1:0] pinRaw;
  logic [PW-1:0] sync1_reg;
  logic [PW-1:0] sync2_reg;

  assign pinRaw = {sampStart, extStart, lineFault, ctlIn, ttlZ, ttlB, ttlA, diffZ, diffB, diffA};

  // RL12 two-flop sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pinRaw;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [CW-1:0] count_reg [NCH];
  logic [CW-1:0] count_next [NCH];
  logic [CW-1:0] preset_reg [NCH];
  logic [CW-1:0] preset_next [NCH];
  logic [CFG_W-1:0] cfg_reg [NCH];
  logic [CFG_W-1:0] cfg_next [NCH];
  logic [FW-1:0] filt_reg [NCH];
  logic [FW-1:0] filt_next [NCH];
  logic [NCH-1:0] run_reg, run_next;
  logic [SW-1:0] stat_reg, stat_next;
  logic [SW-1:0] mask_reg, mask_next;
  logic [TW-1:0] tmrPer_reg, tmrPer_next;
  logic [1:0] src_reg, src_next;
  logic extPrev_reg, sampPrev_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  logic tmrEv;

  function automatic logic addrOk(input logic [11:0] a);
    addrOk = (a[1:0] == 2'h0) && ((a[11:7] == A_CH_HI) || (a <= A_SRC));
  endfunction

  function automatic logic [FW-1:0] clampFilt(input logic [31:0] v);
    if (v == 32'h0) clampFilt = FW'(1);
    else if (v > 32'(FILT_MAX)) clampFilt = FW'(FILT_MAX);
    else clampFilt = v[FW-1:0];
  endfunction

  // ----------------------------------------
  // Noise filters
  // ----------------------------------------
  logic [3:0] tick_reg, tick_next;
  logic tick;
  logic [NF-1:0] fIn, fOut_reg, fOut_next, fPrev_reg;
  logic [FW-1:0] fCnt_reg [NF];
  logic [FW-1:0] fCnt_next [NF];

  assign tick = (tick_reg == 4'(FILT_TICK_CYC - 1));

  always_comb begin
    tick_next = tick ? 4'h0 : tick_reg + 4'h1;
    fOut_next = fOut_reg;
    fCnt_next = fCnt_reg;
    for (int c = 0; c < NCH; c++) begin
      // RL5 input select
      fIn[4*c] = cfg_reg[c][CFG_DIFF] ? sync2_reg[c] : sync2_reg[3*NCH+c];
      fIn[4*c+1] = cfg_reg[c][CFG_DIFF] ? sync2_reg[NCH+c] : sync2_reg[4*NCH+c];
      fIn[4*c+2] = cfg_reg[c][CFG_DIFF] ? sync2_reg[2*NCH+c] : sync2_reg[5*NCH+c];
      fIn[4*c+3] = sync2_reg[6*NCH+c];
    end
    for (int i = 0; i < NF; i++) begin
      // RL7 bypass or filter
      if (!cfg_reg[i/4][CFG_FEN]) begin
        fOut_next[i] = fIn[i];
        fCnt_next[i] = '0;
      end else if (fIn[i] == fOut_reg[i]) begin
        fCnt_next[i] = '0;
      end else if (tick) begin
        // RL8 RL13 per-channel delay
        if (FW'(fCnt_reg[i] + FW'(1)) >= filt_reg[i/4]) begin
          fOut_next[i] = fIn[i];
          fCnt_next[i] = '0;
        end else begin
          fCnt_next[i] = FW'(fCnt_reg[i] + FW'(1));
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= '0;
      fOut_reg <= '0;
      fPrev_reg <= '0;
      fCnt_reg <= '{default: '0};
    end else begin
      tick_reg <= tick_next;
      fOut_reg <= fOut_next;
      fPrev_reg <= fOut_reg;
      fCnt_reg <= fCnt_next;
    end
  end

  // ----------------------------------------
  // Interval timer
  // ----------------------------------------
  logic [MW-1:0] ms_reg, ms_next;
  logic [TW-1:0] per_reg, per_next;
  logic wrEn;

  assign wrEn = psel && penable && pready_reg && pwrite && addrOk(paddr);

  always_comb begin
    ms_next = ms_reg;
    per_next = per_reg;
    tmrEv = 1'b0;
    if (tmrPer_reg == '0 || (wrEn && paddr == A_TMR)) begin
      ms_next = '0;
      per_next = '0;
    end else if (ms_reg == MW'(MS_CYC - 1)) begin
      ms_next = '0;
      // RL10 RL11 ms interval
      if (TW'(per_reg + TW'(1)) == tmrPer_reg) begin
        per_next = '0;
        tmrEv = 1'b1;
      end else begin
        per_next = TW'(per_reg + TW'(1));
      end
    end else begin
      ms_next = MW'(ms_reg + MW'(1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_reg <= '0;
      per_reg <= '0;
    end else begin
      ms_reg <= ms_next;
      per_reg <= per_next;
    end
  end

  // ----------------------------------------
  // Counters, control and registers
  // ----------------------------------------
  logic a, ap, b, bp, zRise, ctRise, ctFall, step, up, dn, startAll;
  logic [2:0] chSel;
  logic [1:0] sub;
  logic isCh;

  assign chSel = paddr[6:4];
  assign sub = paddr[3:2];
  assign isCh = (paddr[11:7] == A_CH_HI);

  always_comb begin
    a = 1'b0;
    ap = 1'b0;
    b = 1'b0;
    bp = 1'b0;
    zRise = 1'b0;
    ctRise = 1'b0;
    ctFall = 1'b0;
    step = 1'b0;
    up = 1'b0;
    dn = 1'b0;
    count_next = count_reg;
    preset_next = preset_reg;
    cfg_next = cfg_reg;
    filt_next = filt_reg;
    run_next = run_reg;
    mask_next = mask_reg;
    tmrPer_next = tmrPer_reg;
    src_next = src_reg;
    stat_next = stat_reg;
    // RL14 start sources
    startAll = (src_reg[SRC_EXT] && sync2_reg[PW-2] && !extPrev_reg)
      || (src_reg[SRC_SAMP] && sync2_reg[PW-1] && !sampPrev_reg);
    if (wrEn && paddr == A_RUN) run_next = pwdata[NCH-1:0];
    if (wrEn && paddr == A_MASK) mask_next = pwdata[SW-1:0];
    if (wrEn && paddr == A_SRC) src_next = pwdata[1:0];
    // RL11 clamp to 6553 ms maximum; 0 is kept and stops the timer
    if (wrEn && paddr == A_TMR) tmrPer_next = (pwdata > 32'(TMR_MAX_MS)) ? TMR_MAX_MS : pwdata[TW-1:0];
    if (wrEn && paddr == A_STAT) stat_next = stat_reg & ~pwdata[SW-1:0];
    // RL10 timer event
    if (tmrEv) stat_next[STAT_TMR] = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      a = fOut_reg[4*c];
      ap = fPrev_reg[4*c];
      b = fOut_reg[4*c+1];
      bp = fPrev_reg[4*c+1];
      zRise = fOut_reg[4*c+2] && !fPrev_reg[4*c+2];
      ctRise = fOut_reg[4*c+3] && !fPrev_reg[4*c+3];
      ctFall = !fOut_reg[4*c+3] && fPrev_reg[4*c+3];
      step = (a ^ ap) ^ (b ^ bp);
      up = 1'b0;
      dn = 1'b0;
      // RL2 counting modes
      unique case (enc8_mode_t'(cfg_reg[c][1:0]))
        ENC8_QUAD: begin
          // RL15 direction from phase order
          up = step && !(ap ^ b);
          dn = step && (ap ^ b);
        end
        ENC8_UPDN: begin
          up = a && !ap && !(b && !bp);
          dn = b && !bp && !(a && !ap);
        end
        ENC8_GATE: begin
          up = a && !ap && b;
        end
        default: begin
          up = 1'b0;
        end
      endcase
      // RL9 start/stop function
      if (enc8_ctl_t'(cfg_reg[c][CFG_CTL+:2]) == ENC8_CSS && ctFall) run_next[c] = 1'b0;
      if ((enc8_ctl_t'(cfg_reg[c][CFG_CTL+:2]) == ENC8_CSS && ctRise) || startAll) run_next[c] = 1'b1;
      // RL6 disconnect sticky
      if (cfg_reg[c][CFG_DIFF] && sync2_reg[7*NCH+c]) stat_next[c] = 1'b1;
      // RL4 RL9 count update
      if (wrEn && isCh && chSel == 3'(c) && sub == S_COUNT) begin
        count_next[c] = pwdata;
      end else if ((cfg_reg[c][CFG_ZCLR] && zRise)
          || (enc8_ctl_t'(cfg_reg[c][CFG_CTL+:2]) == ENC8_CCLR && ctRise)) begin
        count_next[c] = '0;
      end else if (enc8_ctl_t'(cfg_reg[c][CFG_CTL+:2]) == ENC8_CPRE && ctRise) begin
        count_next[c] = preset_reg[c];
      end else if (run_reg[c] && up) begin
        // RL1 RL3 RL16 wrapping binary
        count_next[c] = count_reg[c] + 32'h1;
      end else if (run_reg[c] && dn) begin
        count_next[c] = count_reg[c] - 32'h1;
      end
      if (wrEn && isCh && chSel == 3'(c)) begin
        if (sub == S_PRESET) preset_next[c] = pwdata;
        if (sub == S_CFG) cfg_next[c] = pwdata[CFG_W-1:0];
        if (sub == S_FILT) filt_next[c] = clampFilt(pwdata);
      end
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '{default: '0};
      preset_reg <= '{default: '0};
      cfg_reg <= '{default: CFG_RST};
      filt_reg <= '{default: FILT_RST};
      run_reg <= '0;
      stat_reg <= '0;
      mask_reg <= '0;
      tmrPer_reg <= '0;
      src_reg <= '0;
      extPrev_reg <= 1'b0;
      sampPrev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      preset_reg <= preset_next;
      cfg_reg <= cfg_next;
      filt_reg <= filt_next;
      run_reg <= run_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      tmrPer_reg <= tmrPer_next;
      src_reg <= src_next;
      extPrev_reg <= sync2_reg[PW-2];
      sampPrev_reg <= sync2_reg[PW-1];
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Data is captured in the setup cycle so the access phase needs no wait state.
  always_comb begin
    logic [31:0] rd;
    rd = 32'h0;
    if (isCh) begin
      unique case (sub)
        S_COUNT: rd = count_reg[chSel];
        S_PRESET: rd = preset_reg[chSel];
        S_CFG: rd = 32'(cfg_reg[chSel]);
        S_FILT: rd = 32'(filt_reg[chSel]);
      endcase
    end else begin
      unique case (paddr)
        A_RUN: rd = 32'(run_reg);
        A_STAT: rd = 32'(stat_reg);
        A_MASK: rd = 32'(mask_reg);
        A_TMR: rd = 32'(tmrPer_reg);
        A_SRC: rd = 32'(src_reg);
        A_CTLIN: begin
          for (int c = 0; c < NCH; c++) begin
            rd[c] = fOut_reg[4*c+3];
          end
        end
        default: rd = 32'h0;
      endcase
    end
    pready_next = psel && !penable;
    pslverr_next = psel && !penable && !addrOk(paddr);
    prdata_next = prdata_reg;
    if (psel && !penable) prdata_next = (addrOk(paddr) && !pwrite) ? rd : 32'h0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

endmodule // enc8_counter_top

// file: enc8_pkg.sv
// Constants, field layouts and modes of the eight-channel encoder counter.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package enc8_pkg;

  // ----------------------------------------
  // Sizes and clock
  // ----------------------------------------
  localparam int unsigned NCH = 8;
  localparam int unsigned CW = 32;
  localparam int unsigned CLK_MHZ = 100;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned FILT_UNIT_NS = 100;
  localparam int unsigned FILT_TICK_CYC = FILT_UNIT_NS * CLK_MHZ / 1000;
  localparam int unsigned FILT_MAX_NS = 1638400;
  localparam int unsigned FILT_MAX = FILT_MAX_NS / FILT_UNIT_NS;
  localparam int unsigned FW = 15;
  localparam int unsigned TMR_UNIT_MS = 1;
  localparam int unsigned TMR_UNIT_CYC = TMR_UNIT_MS * CLK_MHZ * 1000;
  localparam int unsigned TW = 13;
  localparam logic [TW-1:0] TMR_MAX_MS = 13'h1999;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] A_RUN = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_MASK = 12'h008;
  localparam logic [11:0] A_TMR = 12'h00c;
  localparam logic [11:0] A_CTLIN = 12'h010;
  localparam logic [11:0] A_SRC = 12'h014;
  localparam logic [4:0] A_CH_HI = 5'h02;
  localparam logic [1:0] S_COUNT = 2'h0;
  localparam logic [1:0] S_PRESET = 2'h1;
  localparam logic [1:0] S_CFG = 2'h2;
  localparam logic [1:0] S_FILT = 2'h3;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int unsigned CFG_W = 7;
  localparam int unsigned CFG_DIFF = 2;
  localparam int unsigned CFG_CTL = 3;
  localparam int unsigned CFG_FEN = 5;
  localparam int unsigned CFG_ZCLR = 6;
  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
  localparam logic [FW-1:0] FILT_RST = 15'h0001;
  localparam int unsigned STAT_TMR = 8;
  localparam int unsigned SW = 9;
  localparam int unsigned SRC_EXT = 0;
  localparam int unsigned SRC_SAMP = 1;

  typedef enum logic [1:0] {
    ENC8_QUAD = 2'h0,
    ENC8_UPDN = 2'h1,
    ENC8_GATE = 2'h3
  } enc8_mode_t;

  typedef enum logic [1:0] {
    ENC8_CSS = 2'h0,
    ENC8_CPRE = 2'h1,
    ENC8_CGPI = 2'h3,
    ENC8_CCLR = 2'h2
  } enc8_ctl_t;

endpackage

// file: enc8_props.sv
// Port checker for the eight-channel encoder counter.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
module enc8_props
  import enc8_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire setup = psel && !penable;

  a_ready_after_setup: assert property (setup |=> pready && psel && penable)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (setup && paddr >= 12'h018 && paddr < 12'h100 |=> pslverr)
    else $error("unmapped access not refused");
  a_err_unaligned: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  a_mapped_ok: assert property (setup && paddr < 12'h018 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_err_rdata_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returns data");
  a_rdata_holds: assert property (!$past(setup) |-> $stable(prdata))
    else $error("read data changed outside a transfer");
  // Irq is registered from the next status and mask, so it falls at the very edge that takes the write.
  a_irq_clear_src: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without a write");
endmodule // enc8_props

bind enc8_counter_top enc8_props enc8_props_inst (
  .clk(clk),
  .rst_n(rst_n),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irq(irq)
);

// file: enc8_encoder_model.sv
// Behavioural model of eight encoders: phases A, B and index per channel.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
module enc8_encoder_model (
  input wire logic clk,
  output logic [7:0] encA,
  output logic [7:0] encB,
  output logic [7:0] encZ
);
  logic [1:0] ph [8] = '{default: 2'h0};
  initial begin
    encA = 8'h00;
    encB = 8'h00;
    encZ = 8'h00;
  end
  // Gray steps 00,10,11,01 give A leading for positive n; one edge per 3 cycles.
  task automatic quad(input int ch, input int n);
    for (int i = 0; i < (n < 0 ? -n : n); i++) begin
      @(posedge clk);
      ph[ch] = ph[ch] + (n < 0 ? 2'h3 : 2'h1);
      encA[ch] <= ph[ch][0] ^ ph[ch][1];
      encB[ch] <= ph[ch][1];
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic setl(input int w, input int ch, input logic v);
    @(posedge clk);
    case (w)
      0: encA[ch] <= v;
      1: encB[ch] <= v;
      default: encZ[ch] <= v;
    endcase
  endtask
  task automatic pulse(input int w, input int ch, input int hi);
    setl(w, ch, 1'b1);
    repeat (hi - 1) @(posedge clk);
    setl(w, ch, 1'b0);
    repeat (hi - 1) @(posedge clk);
  endtask
endmodule // enc8_encoder_model

// file: tb.sv
// Self-checking bench for the encoder counter over APB.
// Assumes a short millisecond (MS_CYC 20) so the timer fires quickly.
`timescale 1ns/1ps
module tb import enc8_pkg::*;;
  logic clk;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [7:0] ctlIn = 8'h00;
  logic [7:0] lineFault = 8'h00;
  logic extStart = 1'b0;
  logic sampStart = 1'b0;
  logic [7:0] dsel = 8'h00;
  logic [7:0] encA;
  logic [7:0] encB;
  logic [7:0] encZ;
  int errors = 0;
  int check_count = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  enc8_counter_top #(.MS_CYC(20)) enc8_counter_top_inst (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .diffA(encA & dsel), .diffB(encB & dsel), .diffZ(encZ & dsel),
    .ttlA(encA & ~dsel), .ttlB(encB & ~dsel), .ttlZ(encZ & ~dsel), .ctlIn(ctlIn),
    .lineFault(lineFault), .extStart(extStart), .sampStart(sampStart), .irq(irq)
  );
  enc8_encoder_model enc8_encoder_model_inst (
    .clk(clk), .encA(encA), .encB(encB), .encZ(encZ)
  );

  task automatic end_sim();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // The master holds the request until pready; the wait is bounded.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  // Reads wait a few cycles first so pin changes have crossed the synchronisers.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    repeat (6) @(posedge clk);
    apb(a, 1'b0, 32'h0, r, e);
    chk($sformatf("reg %h", a), r, exp);
  endtask
  task automatic rderr(input logic [11:0] a);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("errdata", r, 32'h0);
  endtask
  function automatic logic [11:0] ca(input int ch, input logic [1:0] s);
    return 12'h100 + 12'(ch * 16) + {8'h00, s, 2'h0};
  endfunction

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(ca(0, S_CFG), 32'h0);
    rd(ca(5, S_FILT), 32'h1);
    rd(A_RUN, 32'h0);
    rderr(12'h018);
    rderr(12'h102);
    wr(A_RUN, 32'h01);
    enc8_encoder_model_inst.quad(0, 6);
    rd(ca(0, S_COUNT), 32'h6);
    enc8_encoder_model_inst.quad(0, -9);
    rd(ca(0, S_COUNT), 32'hffff_fffd);
    wr(ca(0, S_CFG), 32'h40);
    enc8_encoder_model_inst.pulse(2, 0, 3);
    rd(ca(0, S_COUNT), 32'h0);
    wr(ca(1, S_COUNT), 32'hffff_fffe);
    rd(ca(1, S_COUNT), 32'hffff_fffe);
    wr(ca(1, S_CFG), 32'h1);
    wr(A_RUN, 32'h03);
    repeat (3) enc8_encoder_model_inst.pulse(0, 1, 5);
    rd(ca(1, S_COUNT), 32'h1);
    enc8_encoder_model_inst.pulse(1, 1, 5);
    rd(ca(1, S_COUNT), 32'h0);
    wr(ca(2, S_CFG), 32'h3);
    wr(A_RUN, 32'h07);
    enc8_encoder_model_inst.setl(1, 2, 1'b1);
    repeat (2) enc8_encoder_model_inst.pulse(0, 2, 5);
    enc8_encoder_model_inst.setl(1, 2, 1'b0);
    enc8_encoder_model_inst.pulse(0, 2, 5);
    rd(ca(2, S_COUNT), 32'h2);
    dsel <= 8'h08;
    wr(A_RUN, 32'h0f);
    enc8_encoder_model_inst.quad(3, 4);
    rd(ca(3, S_COUNT), 32'h0);
    wr(ca(3, S_CFG), 32'h4);
    enc8_encoder_model_inst.quad(3, 4);
    rd(ca(3, S_COUNT), 32'h4);
    lineFault <= 8'h08;
    wr(A_MASK, 32'h08);
    rd(A_STAT, 32'h08);
    chk("irq", {31'h0, irq}, 32'h1);
    lineFault <= 8'h00;
    wr(A_STAT, 32'h08);
    rd(A_STAT, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(ca(4, S_COUNT), 32'h55);
    wr(ca(4, S_CFG), 32'h10);
    ctlIn <= 8'h10;
    rd(ca(4, S_COUNT), 32'h0);
    ctlIn <= 8'h00;
    wr(ca(4, S_PRESET), 32'h1234);
    wr(ca(4, S_CFG), 32'h08);
    ctlIn <= 8'h10;
    rd(ca(4, S_COUNT), 32'h1234);
    ctlIn <= 8'h00;
    wr(ca(4, S_CFG), 32'h0);
    wr(A_RUN, 32'h0);
    ctlIn <= 8'h10;
    rd(A_RUN, 32'h10);
    ctlIn <= 8'h00;
    rd(A_RUN, 32'h0);
    wr(ca(4, S_CFG), 32'h18);
    ctlIn <= 8'h10;
    rd(A_CTLIN, 32'h10);
    rd(A_RUN, 32'h0);
    wr(ca(5, S_FILT), 32'h0);
    rd(ca(5, S_FILT), 32'h1);
    wr(ca(5, S_FILT), 32'h3);
    wr(ca(5, S_CFG), 32'h21);
    wr(A_RUN, 32'h20);
    enc8_encoder_model_inst.pulse(0, 5, 10);
    rd(ca(5, S_COUNT), 32'h0);
    enc8_encoder_model_inst.pulse(0, 5, 50);
    rd(ca(5, S_COUNT), 32'h1);
    wr(A_RUN, 32'h0);
    wr(A_SRC, 32'h1);
    extStart <= 1'b1;
    rd(A_RUN, 32'hff);
    extStart <= 1'b0;
    wr(A_RUN, 32'h0);
    wr(A_SRC, 32'h2);
    sampStart <= 1'b1;
    rd(A_RUN, 32'hff);
    wr(A_TMR, 32'h1fff);
    rd(A_TMR, 32'h1999);
    wr(A_TMR, 32'h2);
    wr(A_STAT, 32'h100);
    wr(A_MASK, 32'h100);
    repeat (50) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(A_TMR, 32'h0);
    wr(A_STAT, 32'h100);
    rd(A_STAT, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(ca(6, S_CFG), 32'h2);
    enc8_encoder_model_inst.quad(6, 4);
    rd(ca(6, S_COUNT), 32'h0);
    rd(ca(0, S_COUNT), 32'h0);
    end_sim();
  end
endmodule // tb
